// file: load_store_unit.sv
// Load/store unit with float moves, reservation and store gathering
`timescale 1ns/100ps
module load_store_unit (
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	input  wire logic [3:0]           i_reg_addr,
	input  wire logic [31:0]          i_reg_wdata,
	input  wire logic                 i_reg_wr,
	input  wire logic                 i_reg_rd,
	output logic      [31:0]          o_reg_rdata,
	input  wire logic                 i_fmv_valid,
	input  wire lsu_pkg::fmove_type   i_fmv_op,
	input  wire logic                 i_fmv_rc,
	input  wire logic [63:0]          i_fmv_src,
	input  wire logic [3:0]           i_float_status_control_register_flags,
	output logic                      o_fmv_done,
	output logic      [63:0]          o_fmv_result,
	output logic                      o_cr1_we,
	output logic      [3:0]           o_cr1,
	input  wire logic                 i_op_valid,
	output logic                      o_op_ready,
	input  wire lsu_pkg::kind_type    i_op_kind,
	input  wire lsu_pkg::size_type    i_op_size,
	input  wire logic [31:0]          i_op_ea,
	input  wire logic [63:0]          i_op_sdata,
	input  wire logic                 i_op_update,
	input  wire logic [4:0]           i_op_base,
	input  wire logic [4:0]           i_op_tgt,
	input  wire logic                 i_op_sign,
	input  wire logic                 i_op_brev,
	input  wire logic                 i_op_wt,
	input  wire logic                 i_op_ci,
	input  wire logic                 i_op_guard,
	input  wire logic                 i_op_tsearch,
	input  wire logic                 i_op_barrier,
	input  wire logic                 i_tlb_miss,
	output logic                      o_bus_req,
	output logic                      o_bus_write,
	output logic                      o_bus_global,
	output logic      [31:0]          o_bus_addr,
	output logic      [63:0]          o_bus_wdata,
	output logic      [7:0]           o_bus_be,
	input  wire logic                 i_bus_ack,
	input  wire logic                 i_bus_fault,
	input  wire logic [63:0]          i_bus_rdata,
	output logic                      o_ld_valid,
	output logic      [63:0]          o_ld_data,
	output logic      [4:0]           o_ld_tgt,
	output logic                      o_upd_valid,
	output logic      [4:0]           o_upd_idx,
	output logic      [31:0]          o_upd_ea,
	output logic                      o_stc_valid,
	output logic                      o_stc_ok,
	output logic                      o_fault
);
	import lsu_pkg::*;

	////////////////////////////////////////////////////////////////
	function automatic logic [63:0] swap_bytes(input logic [63:0] d, input size_type s);
		logic [63:0] r;
		r = d;
		for (int i = 0; i < 8; i++) begin
			r[8*i +: 8] = d[8*(7-i) +: 8];
		end
		unique case (s)
			SZ_BYTE:  swap_bytes = {56'h0, d[7:0]};
			SZ_HALF:  swap_bytes = {48'h0, r[63:48]};
			SZ_WORD:  swap_bytes = {32'h0, r[63:32]};
			SZ_DWORD: swap_bytes = r;
		endcase
	endfunction : swap_bytes

	function automatic logic [63:0] trim(input logic [63:0] d, input size_type s);
		unique case (s)
			SZ_BYTE:  trim = {56'h0, d[7:0]};
			SZ_HALF:  trim = {48'h0, d[15:0]};
			SZ_WORD:  trim = {32'h0, d[31:0]};
			SZ_DWORD: trim = d;
		endcase
	endfunction : trim

	////////////////////////////////////////////////////////////////
	// Float moves
	logic        fmv_done_reg, fmv_done_next;
	logic [63:0] fmv_res_reg,  fmv_res_next;
	logic        cr1_we_reg,   cr1_we_next;
	logic [3:0]  cr1_reg,      cr1_next;

	// Status flags are only read here; nothing writes float status
	always_comb begin
		fmv_done_next = i_fmv_valid;
		fmv_res_next  = fmv_res_reg;
		cr1_we_next   = 1'b0;
		cr1_next      = cr1_reg;
		if (i_fmv_valid) begin
			fmv_res_next = i_fmv_src;
			unique case (i_fmv_op)
				FM_COPY: fmv_res_next[SIGN_BIT] = i_fmv_src[SIGN_BIT];
				FM_NEG:  fmv_res_next[SIGN_BIT] = ~i_fmv_src[SIGN_BIT];
				FM_ABS:  fmv_res_next[SIGN_BIT] = 1'b0;
				FM_NABS: fmv_res_next[SIGN_BIT] = 1'b1;
			endcase
			if (i_fmv_rc) begin
				cr1_we_next = 1'b1;
				cr1_next    = i_float_status_control_register_flags;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fmv_done_reg <= 1'b0;
			fmv_res_reg  <= 64'h0;
			cr1_we_reg   <= 1'b0;
			cr1_reg      <= 4'h0;
		end else begin
			fmv_done_reg <= fmv_done_next;
			fmv_res_reg  <= fmv_res_next;
			cr1_we_reg   <= cr1_we_next;
			cr1_reg      <= cr1_next;
		end
	end

	assign o_fmv_done   = fmv_done_reg;
	assign o_fmv_result = fmv_res_reg;
	assign o_cr1_we     = cr1_we_reg;
	assign o_cr1        = cr1_reg;

	////////////////////////////////////////////////////////////////
	// Memory access sequencer
	state_type   state_reg, state_next;
	kind_type    kind_reg, kind_next;
	size_type    size_reg, size_next;
	logic [31:0] ea_reg, ea_next;
	logic [63:0] sdata_reg, sdata_next;
	logic        upd_reg, upd_next;
	logic [4:0]  base_reg, base_next;
	logic [4:0]  tgt_reg, tgt_next;
	logic        sign_reg, sign_next;
	logic        brev_reg, brev_next;
	logic        glob_reg, glob_next;
	logic        stcok_reg, stcok_next;
	logic [63:0] lo_reg, lo_next;
	logic        slot_v_reg, slot_v_next;
	logic [31:0] slot_ea_reg, slot_ea_next;
	logic [63:0] slot_d_reg, slot_d_next;
	logic [7:0]  slot_be_reg, slot_be_next;
	logic        resv_v_reg, resv_v_next;
	logic [31:RESV_LSB] resv_blk_reg, resv_blk_next;
	logic        sge_reg, sge_next;
	logic [7:0]  gcnt_reg, gcnt_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        ld_v_reg, ld_v_next;
	logic [63:0] ld_d_reg, ld_d_next;
	logic        upd_v_reg, upd_v_next;
	logic        stc_v_reg, stc_v_next;
	logic        stc_ok_reg, stc_ok_next;
	logic        fault_reg, fault_next;

	logic         gatherable, merge, accept, split, last_ack, is_write;
	logic [4:0]   nbytes;
	logic [15:0]  be_wide;
	logic [127:0] st_wide, rd_wide;
	logic [63:0]  raw, lane;

	// Word store into uncached or write-through, unguarded space only
	assign gatherable = sge_reg && i_op_kind == K_STORE && i_op_size == SZ_WORD
		&& i_op_ea[1:0] == 2'b00 && (i_op_wt || i_op_ci) && !i_op_guard
		&& !i_op_brev && !i_op_tsearch;
	// Other word of the same double word, in either order
	assign merge = slot_v_reg && gatherable && !i_op_barrier
		&& i_op_ea[31:3] == slot_ea_reg[31:3] && i_op_ea[2] != slot_ea_reg[2];
	// One operation at a time keeps issue in program order
	assign o_op_ready = state_reg == ST_IDLE && (!slot_v_reg || merge);
	assign accept     = i_op_valid && o_op_ready;

	always_comb begin
		unique case (size_reg)
			SZ_BYTE:  nbytes = 5'h01;
			SZ_HALF:  nbytes = 5'h02;
			SZ_WORD:  nbytes = 5'h04;
			SZ_DWORD: nbytes = 5'h08;
		endcase
	end
	assign split    = {2'b00, ea_reg[2:0]} + nbytes > DW_BYTES;
	assign is_write = kind_reg != K_LOAD && kind_reg != K_LRES;
	// Failed conditional still reaches the bus, with no byte written
	assign be_wide  = (kind_reg == K_SCOND && !stcok_reg) ? 16'h0000
		: 16'(trim(64'hFFFF_FFFF_FFFF_FFFF, size_reg) >> 0 != 0 ? (16'h00FF
		>> (4'h8 - nbytes[3:0]) | (nbytes[3] ? 16'h00FF : 16'h0000)) : 16'h0000)
		<< ea_reg[2:0];
	assign st_wide  = 128'(sdata_reg) << {ea_reg[2:0], 3'b000};
	assign last_ack = i_bus_ack && !i_tlb_miss
		&& ((state_reg == ST_ACC1 && !split) || state_reg == ST_ACC2);
	assign rd_wide  = state_reg == ST_ACC2 ? {i_bus_rdata, lo_reg} : {64'h0, i_bus_rdata};
	assign raw      = 64'(rd_wide >> {ea_reg[2:0], 3'b000});
	// Same path for algebraic and reversed forms: no extra cycle
	always_comb begin
		lane = brev_reg ? swap_bytes(raw, size_reg) : trim(raw, size_reg);
		if (sign_reg && size_reg == SZ_HALF) begin
			lane = {{48{raw[15]}}, raw[15:0]};
		end
	end

	always_comb begin
		o_bus_req    = 1'b0;
		o_bus_write  = is_write;
		o_bus_global = glob_reg;
		o_bus_addr   = {ea_reg[31:3], 3'b000};
		o_bus_wdata  = st_wide[63:0];
		o_bus_be     = be_wide[7:0];
		unique case (state_reg)
			ST_IDLE: o_bus_write = 1'b0;
			// A reload in progress just holds the request back
			ST_ACC1: o_bus_req = !i_tlb_miss;
			ST_ACC2: begin
				o_bus_req   = !i_tlb_miss;
				o_bus_addr  = {ea_reg[31:3] + 29'h1, 3'b000};
				o_bus_wdata = st_wide[127:64];
				o_bus_be    = be_wide[15:8];
			end
			ST_GSEND: begin
				o_bus_req    = 1'b1;
				o_bus_write  = 1'b1;
				o_bus_global = 1'b0;
				o_bus_addr   = {slot_ea_reg[31:3], 3'b000};
				o_bus_wdata  = slot_d_reg;
				o_bus_be     = slot_be_reg;
			end
		endcase
	end

	always_comb begin
		state_next    = state_reg;
		kind_next     = kind_reg;
		size_next     = size_reg;
		ea_next       = ea_reg;
		sdata_next    = sdata_reg;
		upd_next      = upd_reg;
		base_next     = base_reg;
		tgt_next      = tgt_reg;
		sign_next     = sign_reg;
		brev_next     = brev_reg;
		glob_next     = glob_reg;
		stcok_next    = stcok_reg;
		lo_next       = lo_reg;
		slot_v_next   = slot_v_reg;
		slot_ea_next  = slot_ea_reg;
		slot_d_next   = slot_d_reg;
		slot_be_next  = slot_be_reg;
		resv_v_next   = resv_v_reg;
		resv_blk_next = resv_blk_reg;
		gcnt_next     = gcnt_reg;
		ld_v_next     = 1'b0;
		ld_d_next     = ld_d_reg;
		upd_v_next    = 1'b0;
		stc_v_next    = 1'b0;
		stc_ok_next   = stc_ok_reg;
		fault_next    = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (merge && i_op_valid) begin
					slot_d_next[32*i_op_ea[2] +: 32] = i_op_sdata[31:0];
					slot_be_next = 8'hFF;
					state_next   = ST_GSEND;
				end else if (slot_v_reg) begin
					// Held store no longer has a partner waiting behind it
					state_next = ST_GSEND;
				end else if (accept && gatherable) begin
					slot_v_next  = 1'b1;
					slot_ea_next = i_op_ea;
					slot_d_next  = 64'(i_op_sdata[31:0]) << {i_op_ea[2], 5'b00000};
					slot_be_next = i_op_ea[2] ? 8'hF0 : 8'h0F;
				end else if (accept) begin
					// Each request is its own access, register values never combined
					state_next = ST_ACC1;
					kind_next  = i_op_kind;
					size_next  = i_op_size;
					ea_next    = i_op_ea;
					sdata_next = i_op_brev ? swap_bytes(i_op_sdata, i_op_size)
						: trim(i_op_sdata, i_op_size);
					upd_next   = i_op_update && i_op_base != 5'h00
						&& (i_op_kind != K_LOAD || i_op_base != i_op_tgt);
					base_next  = i_op_base;
					tgt_next   = i_op_tgt;
					sign_next  = i_op_sign;
					brev_next  = i_op_brev;
					glob_next  = !i_op_ci;
					stcok_next = resv_v_reg && resv_blk_reg == i_op_ea[31:RESV_LSB];
					if (i_op_kind == K_LRES) begin
						resv_v_next   = 1'b1;
						resv_blk_next = i_op_ea[31:RESV_LSB];
					end
					if (i_op_kind == K_SCOND) begin
						resv_v_next = 1'b0;
					end
				end
			end
			ST_ACC1, ST_ACC2: begin
				// Only a real fault restarts; write-through is no fault source
				if (i_bus_ack && !i_tlb_miss && i_bus_fault) begin
					fault_next = 1'b1;
					state_next = ST_IDLE;
				end else if (last_ack) begin
					state_next  = ST_IDLE;
					ld_v_next   = !is_write;
					ld_d_next   = lane;
					upd_v_next  = upd_reg;
					stc_v_next  = kind_reg == K_SCOND;
					stc_ok_next = stcok_reg;
				end else if (i_bus_ack && !i_tlb_miss) begin
					lo_next    = i_bus_rdata;
					state_next = ST_ACC2;
				end
			end
			ST_GSEND: begin
				if (i_bus_ack) begin
					slot_v_next = 1'b0;
					fault_next  = i_bus_fault;
					if (slot_be_reg == 8'hFF) begin
						gcnt_next = gcnt_reg + 8'h01;
					end
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Register port
	always_comb begin
		sge_next   = sge_reg;
		rdata_next = 32'h0;
		if (i_reg_wr && i_reg_addr == REG_CFG) begin
			sge_next = i_reg_wdata[CFG_SGE_BIT];
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				REG_CFG:  rdata_next[CFG_SGE_BIT] = sge_reg;
				REG_STAT: begin
					rdata_next[STAT_RESV_BIT] = resv_v_reg;
					rdata_next[STAT_SLOT_BIT] = slot_v_reg;
					rdata_next[STAT_BUSY_BIT] = state_reg != ST_IDLE;
				end
				REG_GCNT: rdata_next[7:0] = gcnt_reg;
				default:  rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg    <= ST_IDLE;
			kind_reg     <= K_LOAD;
			size_reg     <= SZ_BYTE;
			ea_reg       <= 32'h0;
			sdata_reg    <= 64'h0;
			upd_reg      <= 1'b0;
			base_reg     <= 5'h00;
			tgt_reg      <= 5'h00;
			sign_reg     <= 1'b0;
			brev_reg     <= 1'b0;
			glob_reg     <= 1'b0;
			stcok_reg    <= 1'b0;
			lo_reg       <= 64'h0;
			slot_v_reg   <= 1'b0;
			slot_ea_reg  <= 32'h0;
			slot_d_reg   <= 64'h0;
			slot_be_reg  <= 8'h00;
			resv_v_reg   <= 1'b0;
			resv_blk_reg <= '0;
			sge_reg      <= CFG_SGE_RESET;
			gcnt_reg     <= 8'h00;
			rdata_reg    <= 32'h0;
			ld_v_reg     <= 1'b0;
			ld_d_reg     <= 64'h0;
			upd_v_reg    <= 1'b0;
			stc_v_reg    <= 1'b0;
			stc_ok_reg   <= 1'b0;
			fault_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			kind_reg     <= kind_next;
			size_reg     <= size_next;
			ea_reg       <= ea_next;
			sdata_reg    <= sdata_next;
			upd_reg      <= upd_next;
			base_reg     <= base_next;
			tgt_reg      <= tgt_next;
			sign_reg     <= sign_next;
			brev_reg     <= brev_next;
			glob_reg     <= glob_next;
			stcok_reg    <= stcok_next;
			lo_reg       <= lo_next;
			slot_v_reg   <= slot_v_next;
			slot_ea_reg  <= slot_ea_next;
			slot_d_reg   <= slot_d_next;
			slot_be_reg  <= slot_be_next;
			resv_v_reg   <= resv_v_next;
			resv_blk_reg <= resv_blk_next;
			sge_reg      <= sge_next;
			gcnt_reg     <= gcnt_next;
			rdata_reg    <= rdata_next;
			ld_v_reg     <= ld_v_next;
			ld_d_reg     <= ld_d_next;
			upd_v_reg    <= upd_v_next;
			stc_v_reg    <= stc_v_next;
			stc_ok_reg   <= stc_ok_next;
			fault_reg    <= fault_next;
		end
	end

	// Fetches never pass through here, so no fetch sees cached data
	// and none carries the coherence attribute
	assign o_reg_rdata = rdata_reg;
	assign o_ld_valid  = ld_v_reg;
	assign o_ld_data   = ld_d_reg;
	assign o_ld_tgt    = tgt_reg;
	assign o_upd_valid = upd_v_reg;
	assign o_upd_idx   = base_reg;
	assign o_upd_ea    = ea_reg;
	assign o_stc_valid = stc_v_reg;
	assign o_stc_ok    = stc_ok_reg;
	assign o_fault     = fault_reg;

	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	property p_fmv_nabs;
		i_fmv_valid && i_fmv_op == FM_NABS |=> o_fmv_done && o_fmv_result[SIGN_BIT];
	endproperty
	a_fmv_nabs: assert property (p_fmv_nabs) else $error("nabs sign not set");

	property p_cr1_rc;
		o_cr1_we |-> $past(i_fmv_valid) && $past(i_fmv_rc);
	endproperty
	a_cr1_rc: assert property (p_cr1_rc) else $error("cr1 written without rc");

	property p_gather_sge;
		state_reg == ST_GSEND && o_bus_be == 8'hFF |-> sge_reg;
	endproperty
	a_gather_sge: assert property (p_gather_sge) else $error("gather while off");

	property p_stc_bus;
		accept && i_op_kind == K_SCOND && !i_op_tsearch |=> ##[0:40] o_bus_req && o_bus_write;
	endproperty
	a_stc_bus: assert property (p_stc_bus) else $error("no bus write for cond");

	property p_resv_set;
		accept && !gatherable && i_op_kind == K_LRES |=> resv_v_reg
			&& resv_blk_reg == $past(i_op_ea[31:RESV_LSB]);
	endproperty
	a_resv_set: assert property (p_resv_set) else $error("reservation not set");

	property p_upd_base;
		o_upd_valid |-> o_upd_idx != 5'h00 && !o_fault;
	endproperty
	a_upd_base: assert property (p_upd_base) else $error("update to base zero");

	property p_no_split;
		state_reg == ST_ACC1 && !split && i_bus_ack && !i_tlb_miss |=> state_reg != ST_ACC2;
	endproperty
	a_no_split: assert property (p_no_split) else $error("extra access");

	property p_fault_restart;
		o_fault |-> !o_ld_valid && !o_upd_valid && state_reg == ST_IDLE;
	endproperty
	a_fault_restart: assert property (p_fault_restart) else $error("partial commit");

	property p_tlb_stall;
		i_tlb_miss && (state_reg == ST_ACC1 || state_reg == ST_ACC2)
			|=> !o_fault && $stable(state_reg);
	endproperty
	a_tlb_stall: assert property (p_tlb_stall) else $error("reload restarted");

	property p_no_guard_gather;
		i_op_valid && (i_op_guard || i_op_brev || i_op_kind != K_STORE) |-> !gatherable;
	endproperty
	a_no_guard_gather: assert property (p_no_guard_gather) else $error("bad gather");
endmodule : load_store_unit

// file: lsu_pkg.sv
// Constants and types for the load/store unit
package lsu_pkg;
	localparam logic [3:0] REG_CFG       = 4'h0;
	localparam logic [3:0] REG_STAT      = 4'h4;
	localparam logic [3:0] REG_GCNT      = 4'h8;
	localparam int         CFG_SGE_BIT   = 0;
	localparam logic       CFG_SGE_RESET = 1'b0;
	localparam int         STAT_RESV_BIT = 0;
	localparam int         STAT_SLOT_BIT = 1;
	localparam int         STAT_BUSY_BIT = 2;
	localparam int         RESV_LSB      = 5;
	localparam int         SIGN_BIT      = 63;
	localparam logic [4:0] DW_BYTES      = 5'h08;

	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} size_type;
	typedef enum logic [2:0] {
		K_LOAD, K_STORE, K_LRES, K_SCOND, K_ECOW, K_FSTORE
	} kind_type;
	typedef enum logic [1:0] {FM_COPY, FM_NEG, FM_ABS, FM_NABS} fmove_type;
	typedef enum {ST_IDLE, ST_ACC1, ST_ACC2, ST_GSEND} state_type;
endpackage : lsu_pkg

// file: bus_mem_model.sv
// Far-side bus and memory model with wait states and fault injection
`timescale 1ns/100ps
module bus_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	input  wire logic [3:0]  i_delay,
	input  wire logic        i_fault_en,
	input  wire logic [31:0] i_fault_addr,
	output logic             o_ack,
	output logic             o_fault,
	output logic      [63:0] o_rdata
);
	logic [3:0]  wait_reg;
	logic [63:0] junk_reg;
	// Data is only meaningful with ack; otherwise it toggles
	assign o_rdata = o_ack ? {~i_addr, i_addr} : junk_reg;
	assign o_fault = o_ack && i_fault_en && (i_addr == i_fault_addr);
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ack <= 1'b0;
			wait_reg <= 4'h0;
			junk_reg <= 64'hA5A5_5A5A_C3C3_3C3C;
		end else begin
			junk_reg <= ~junk_reg;
			o_ack <= 1'b0;
			if (i_req && !o_ack && wait_reg >= i_delay) begin
				o_ack <= 1'b1;
				wait_reg <= 4'h0;
			end else if (i_req && !o_ack) begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule : bus_mem_model

// file: tb.sv
// Self-checking bench for the load/store unit
`timescale 1ns/100ps
module tb;
	import lsu_pkg::*;
	logic i_clk = 0, i_rstn = 0, i_reg_wr = 0, i_reg_rd = 0, i_fmv_valid = 0, i_fmv_rc = 0;
	logic i_op_valid = 0, i_op_update = 0, i_op_sign = 0, i_op_brev = 0, i_op_wt = 0;
	logic i_op_ci = 0, i_op_guard = 0, i_op_tsearch = 0, i_op_barrier = 0, i_tlb_miss = 0;
	logic i_bus_ack, i_bus_fault, o_fmv_done, o_cr1_we, o_op_ready, o_bus_req, o_bus_write;
	logic o_bus_global, o_ld_valid, o_upd_valid, o_stc_valid, o_stc_ok, o_fault, stc_r, flt_en = 0;
	logic [3:0]  i_reg_addr = 0, i_float_status_control_register_flags = 0, o_cr1, dly = 0;
	logic [31:0] i_reg_wdata = 0, i_op_ea = 0, o_reg_rdata, o_bus_addr, o_upd_ea;
	logic [31:0] flt_a = 0, prev_a, last_a;
	logic [63:0] i_fmv_src = 0, i_op_sdata = 0, i_bus_rdata, o_fmv_result, o_bus_wdata;
	logic [63:0] o_ld_data, last_wd, ld_d;
	logic [7:0]  o_bus_be, last_be;
	logic [1:0]  last_wg;
	logic [4:0]  i_op_base = 0, i_op_tgt = 0, o_ld_tgt, o_upd_idx;
	fmove_type   i_fmv_op = FM_COPY;
	kind_type    i_op_kind = K_LOAD;
	size_type    i_op_size = SZ_BYTE;
	int          error_cnt = 0, samples_checked = 0, beats = 0, lds = 0, flts = 0, bs, ls, fs;
	time         ld_t, acc_t;
	localparam logic [63:0] fsrc = 64'hC008_0000_0000_1234;
	localparam logic [63:0] sgn = 64'h8000_0000_0000_0000;
	load_store_unit load_store_unit_i (.i_clk, .i_rstn, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
		.i_reg_rd, .o_reg_rdata, .i_fmv_valid, .i_fmv_op, .i_fmv_rc, .i_fmv_src, .i_float_status_control_register_flags,
		.o_fmv_done, .o_fmv_result, .o_cr1_we, .o_cr1, .i_op_valid, .o_op_ready, .i_op_kind,
		.i_op_size, .i_op_ea, .i_op_sdata, .i_op_update, .i_op_base, .i_op_tgt, .i_op_sign,
		.i_op_brev, .i_op_wt, .i_op_ci, .i_op_guard, .i_op_tsearch, .i_op_barrier, .i_tlb_miss,
		.o_bus_req, .o_bus_write, .o_bus_global, .o_bus_addr, .o_bus_wdata, .o_bus_be,
		.i_bus_ack, .i_bus_fault, .i_bus_rdata, .o_ld_valid, .o_ld_data, .o_ld_tgt,
		.o_upd_valid, .o_upd_idx, .o_upd_ea, .o_stc_valid, .o_stc_ok, .o_fault);
	bus_mem_model bus_mem_model_i (.i_clk, .i_rstn, .i_req(o_bus_req), .i_addr(o_bus_addr),
		.i_delay(dly), .i_fault_en(flt_en), .i_fault_addr(flt_a), .o_ack(i_bus_ack),
		.o_fault(i_bus_fault), .o_rdata(i_bus_rdata));
	always #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (o_bus_req === 1'b1 && i_bus_ack === 1'b1) begin
			beats++;
			prev_a = last_a;
			last_a = o_bus_addr;
			last_be = o_bus_be;
			last_wd = o_bus_wdata;
			last_wg = {o_bus_write, o_bus_global};
		end
		if (o_ld_valid === 1'b1) begin
			lds++;
			ld_d = o_ld_data;
			ld_t = $time;
		end
		if (o_stc_valid === 1'b1) stc_r = o_stc_ok;
		if (o_fault === 1'b1) flts++;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("Checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
		@(posedge i_clk);
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_clk);
		chk(o_reg_rdata, exp);
		@(posedge i_clk);
	endtask : reg_rd
	// Leaves valid high so a second op can follow in the next cycle
	task automatic op(input kind_type k, input size_type s, input logic [31:0] ea,
			input logic [6:0] at, input logic [4:0] b);
		i_op_valid <= 1'b1;
		i_op_kind <= k;
		i_op_size <= s;
		i_op_ea <= ea;
		i_op_sdata <= {~ea, ea};
		{i_op_sign, i_op_tsearch, i_op_brev, i_op_wt, i_op_ci, i_op_guard, i_op_barrier} <= at;
		i_op_update <= (b != 5'h00);
		i_op_base <= b;
		i_op_tgt <= 5'h07;
		@(negedge i_clk);
		for (int n = 0; n < 50 && o_op_ready !== 1'b1; n++) @(negedge i_clk);
		@(posedge i_clk);
		acc_t = $time;
	endtask : op
	task automatic settle;
		i_op_valid <= 1'b0;
		@(negedge i_clk);
		for (int n = 0; n < 60 && !(o_op_ready === 1'b1 && o_bus_req === 1'b0); n++)
			@(negedge i_clk);
		repeat (3) @(posedge i_clk);
	endtask : settle
	task automatic snap;
		bs = beats;
		ls = lds;
		fs = flts;
	endtask : snap
	task automatic fmv(input fmove_type f, input logic rc, input logic [63:0] exp);
		logic [3:0] old;
		old = o_cr1;
		i_fmv_valid <= 1'b1;
		i_fmv_op <= f;
		i_fmv_rc <= rc;
		i_fmv_src <= fsrc;
		i_float_status_control_register_flags <= {f, rc, 1'b1};
		@(posedge i_clk);
		i_fmv_valid <= 1'b0;
		@(negedge i_clk);
		chk(o_fmv_done, 64'h1);
		chk(o_fmv_result, exp);
		chk(o_cr1_we, rc);
		chk(o_cr1, rc ? {f, rc, 1'b1} : old);
		@(posedge i_clk);
	endtask : fmv
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		reg_rd(REG_CFG, 32'h0);
		reg_rd(REG_STAT, 32'h0);
		reg_rd(REG_GCNT, 32'h0);
		reg_wr(4'hC, 32'hFFFF_FFFF);
		reg_rd(4'hC, 32'h0);
		reg_wr(REG_CFG, 32'h1);
		reg_rd(REG_CFG, 32'h1);
	endtask : t_regs
	task automatic t_fmv;
		fmv(FM_COPY, 1'b1, fsrc);
		fmv(FM_NEG, 1'b0, fsrc ^ sgn);
		fmv(FM_ABS, 1'b1, fsrc & ~sgn);
		fmv(FM_NABS, 1'b0, fsrc | sgn);
	endtask : t_fmv
	task automatic t_load;
		time t0;
		dly <= 4'h3;
		op(K_LOAD, SZ_DWORD, 32'h40, 7'h00, 5'h03);
		settle;
		chk(ld_d, {~32'h40, 32'h40});
		chk({o_ld_tgt, o_upd_idx, o_upd_ea}, {5'h07, 5'h03, 32'h40});
		t0 = ld_t - acc_t;
		op(K_LOAD, SZ_HALF, 32'h52, 7'h40, 5'h00);
		settle;
		chk(ld_t - acc_t, t0);
		op(K_LOAD, SZ_WORD, 32'h54, 7'h10, 5'h00);
		settle;
		chk(ld_t - acc_t, t0);
		chk(ld_d, 64'h0000_0000_AFFF_FFFF);
		op(K_STORE, SZ_DWORD, 32'h48, 7'h00, 5'h05);
		settle;
		chk({last_wd, last_be}, {~32'h48, 32'h48, 8'hFF});
		chk({o_upd_idx, o_upd_ea}, {5'h05, 32'h48});
		chk(last_wg, 2'b11);
	endtask : t_load
	task automatic t_cross;
		dly <= 4'h0;
		snap;
		op(K_LOAD, SZ_WORD, 32'h61, 7'h00, 5'h00);
		settle;
		chk(beats - bs, 1);
		chk(last_wg, 2'b01);
		snap;
		op(K_LOAD, SZ_WORD, 32'h5E, 7'h00, 5'h00);
		settle;
		chk({beats - bs, prev_a, last_a}, {32'h2, 32'h58, 32'h60});
		flt_a <= 32'h60;
		flt_en <= 1'b1;
		snap;
		op(K_LOAD, SZ_WORD, 32'h5E, 7'h00, 5'h00);
		settle;
		chk({flts - fs, lds - ls}, {32'h1, 32'h0});
		flt_en <= 1'b0;
		op(K_LOAD, SZ_WORD, 32'h5E, 7'h00, 5'h00);
		settle;
		chk({beats - bs, lds - ls, prev_a}, {32'h4, 32'h1, 32'h58});
	endtask : t_cross
	task automatic t_tlb;
		i_tlb_miss <= 1'b1;
		snap;
		op(K_LOAD, SZ_DWORD, 32'h80, 7'h00, 5'h00);
		i_op_valid <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk(beats - bs, 0);
		i_tlb_miss <= 1'b0;
		settle;
		chk({lds - ls, flts - fs}, {32'h1, 32'h0});
	endtask : t_tlb
	task automatic t_resv;
		snap;
		op(K_SCOND, SZ_WORD, 32'h300, 7'h08, 5'h00);
		settle;
		chk({beats - bs, 31'h0, stc_r}, {32'h1, 32'h0});
		op(K_LRES, SZ_WORD, 32'h300, 7'h08, 5'h00);
		settle;
		op(K_SCOND, SZ_WORD, 32'h31C, 7'h08, 5'h00);
		settle;
		chk({flts - fs, 31'h0, stc_r}, {32'h0, 32'h1});
		op(K_LRES, SZ_WORD, 32'h300, 7'h08, 5'h00);
		settle;
		op(K_SCOND, SZ_WORD, 32'h320, 7'h08, 5'h00);
		settle;
		chk({beats - bs, 31'h0, stc_r}, {32'h5, 32'h0});
	endtask : t_resv
	task automatic t_gather;
		logic [6:0] a1 [11] = '{7'h08, 7'h04, 7'h08, 7'h0A, 7'h18, 7'h28, 7'h08, 7'h00,
			7'h08, 7'h08, 7'h08};
		kind_type kd [11] = '{K_STORE, K_STORE, K_STORE, K_STORE, K_STORE, K_STORE,
			K_FSTORE, K_STORE, K_STORE, K_ECOW, K_SCOND};
		logic [31:0] ea;
		for (int i = 0; i < 11; i++) begin
			ea = 32'h200 + (i << 4) + ((i == 1) ? 4 : 0);
			reg_wr(REG_CFG, {31'h0, i != 2});
			snap;
			op(kd[i], SZ_WORD, ea, a1[i], 5'h00);
			op(kd[i], SZ_WORD, ea ^ 32'h4, a1[i] | ((i == 8) ? 7'h01 : 7'h00), 5'h00);
			settle;
			chk(beats - bs, (i < 2) ? 1 : 2);
			if (i < 2) chk({last_be, last_a}, {8'hFF, ea & 32'hFFFF_FFF8});
		end
		reg_rd(REG_GCNT, 32'h2);
	endtask : t_gather
	initial begin
		repeat (3) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		t_regs;
		t_fmv;
		t_load;
		t_cross;
		t_tlb;
		t_resv;
		t_gather;
		print_verdict;
	end
	// Whole run needs well under a tenth of this span
	initial begin
		#400000;
		error_cnt++;
		print_verdict;
	end
endmodule : tb
